// *** pkg/cam_map.vh ***
// register map, widths and reset values of the cam follower
// assumes a 32-bit avalon slave with byte addresses, one word per register
`ifndef CAM_MAP_VH
`define CAM_MAP_VH

`define CAM_NSLV      7
`define CAM_SLV_LAST  3'h6
`define CAM_MAX_IDX   9'h0ff
`define CAM_DEPTH     2056
`define CAM_AW        12
`define CAM_DIV_W     56
`define CAM_DIV_CNT   6'h38

`define MSEL_VIRTUAL  4'h8
`define MSEL_RST      4'h0
`define MCYC_RST      23'h000000
`define INTV_RST      23'h000000
`define ORIG_RST      23'h000000

`define R_MSEL        8'h00
`define R_ENABLE      8'h04
`define R_MCYCLE      8'h08
`define R_INTERVAL    8'h0c
`define R_ORIGIN      8'h10
`define R_TBL_ADDR    8'h14
`define R_TBL_DATA    8'h18
`define R_INDEX       8'h1c
`define R_CYCLE_CNT   8'h20
`define R_STATUS      8'h24
`define R_PHASE       8'h28
`define G_CHANGE      3'h2
`define G_ENGAGE      3'h3
`define G_DISENGAGE   3'h4
`define G_SLAVE_POS   3'h5

`endif

// *** hdl/cam_divider.v ***
// serial restoring divider, one quotient bit per clock
// assumes start is pulsed only while idle; divisor must be nonzero
`timescale 1ns/1ps
`include "cam_map.vh"
module cam_divider (
  input  wire                    mclk_i,
  input  wire                    rst_n_i,
  input  wire                    start_i,
  input  wire [`CAM_DIV_W-1:0]   dividend_i,
  input  wire [22:0]             divisor_i,
  output reg  [`CAM_DIV_W-1:0]   quotient_o,
  output reg  [22:0]             remainder_o,
  output reg                     done_o
);
  reg  [5:0]  cnt;
  reg         busy;
  wire [23:0] shifted = {remainder_o, quotient_o[`CAM_DIV_W-1]};
  wire        fits    = shifted >= {1'b0, divisor_i};
  wire [23:0] diff    = shifted - {1'b0, divisor_i};

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quotient_o  <= {`CAM_DIV_W{1'b0}};
      remainder_o <= 23'h000000;
      cnt         <= 6'h00;
      busy        <= 1'b0;
      done_o      <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        quotient_o  <= dividend_i;
        remainder_o <= 23'h000000;
        cnt         <= `CAM_DIV_CNT;
        busy        <= 1'b1;
      end else if (busy) begin
        remainder_o <= fits ? diff[22:0] : shifted[22:0];
        quotient_o  <= {quotient_o[`CAM_DIV_W-2:0], fits};
        cnt         <= cnt - 6'h01;
        if (cnt == 6'h01) begin
          busy   <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule

// *** hdl/cam_table.v ***
// cam table storage: 257 points, eight word slots per point, seven used
// assumes one host write port and one registered read port, same clock
`timescale 1ns/1ps
`include "cam_map.vh"
module cam_table (
  input  wire               mclk_i,
  input  wire               we_i,
  input  wire [`CAM_AW-1:0] waddr_i,
  input  wire [31:0]        wdata_i,
  input  wire [`CAM_AW-1:0] raddr_i,
  output reg  [31:0]        rdata_o
);
  // no reset on purpose: block ram inference
  reg [31:0] mem [0:`CAM_DEPTH-1];

  always @(posedge mclk_i) begin
    if (we_i)
      mem[waddr_i] <= wdata_i;
    rdata_o <= mem[raddr_i];
  end
endmodule

// *** hdl/cam_follower.v ***
// electronic cam engine: wraps a master position and interpolates slave positions
// assumes axis and virtual positions come from counters on mclk_i, and
// sample_tick_i is the one-cycle servo sample enable from a divider
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "cam_map.vh"

// Functional notes
// - up to seven slaves follow one master
// - master select picks exactly one axis
// - master select also accepts virtual axis
// - master position kept modulo master cycle
// - cycle end wraps master position and counts the cam cycle
// - cycle 8388607 max, change 2147483647 max
// - uniform master intervals, at most 256
// - geometry holds interval width and start point
// - entries 0 through 256, one per slave
// - enable written 1 on, 0 off
// - engage at given master position per slave
// - engage point outside cycle engages immediately
// - engaged slave position taken modulo its change
// - disengage at given master position per slave
// - disengage point outside cycle stops instantly
// - host writes table index counter
// - host writes cam cycle counter
module cam_follower (
  input  wire          mclk_i,
  input  wire          rst_n_i,
  input  wire [7:0]    avs_address_i,
  input  wire          avs_read_i,
  input  wire          avs_write_i,
  input  wire [31:0]   avs_writedata_i,
  output reg  [31:0]   avs_readdata_o,
  output wire          avs_waitrequest_o,
  input  wire          sample_tick_i,
  input  wire [255:0]  axis_pos_i,
  input  wire [31:0]   virtual_pos_i,
  output wire [223:0]  slave_pos_o,
  output wire [6:0]    slave_engaged_o,
  output wire          cam_active_o
);
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_DIVI = 6'h02;
  localparam [5:0] S_RDA  = 6'h04;
  localparam [5:0] S_RDB  = 6'h08;
  localparam [5:0] S_RDC  = 6'h10;
  localparam [5:0] S_DIVS = 6'h20;

  reg  [3:0]  msel;
  reg         en;
  reg  [22:0] mcyc;
  reg  [22:0] intv;
  reg  [22:0] orig;
  reg  [11:0] taddr;
  reg  [8:0]  idx;
  reg  [31:0] ycnt;
  reg  [22:0] phase;
  reg  [22:0] old_phase;
  reg  [31:0] prev_pos;
  reg         evt;
  reg         ev_fwd;
  reg         ev_wrap;
  reg         ack;
  reg  [30:0] chg  [0:6];
  reg  [31:0] engp [0:6];
  reg  [31:0] disp [0:6];
  reg  [31:0] spos [0:6];
  reg  [5:0]  st;
  reg  [2:0]  slv;
  reg  [22:0] frac;
  reg  [31:0] pa;
  reg         neg;
  reg  [11:0] raddr;
  reg         dv_start;
  reg  [`CAM_DIV_W-1:0] dv_dividend;
  reg  [31:0] rd_mux;
  wire [31:0] rdata;
  wire [`CAM_DIV_W-1:0] dv_q;
  wire [22:0] dv_r;
  wire        dv_done;
  wire [6:0]  engaged;
  wire [6:0]  arm_e;
  wire [6:0]  arm_d;

  // avalon: one wait cycle for every access, answer in the second cycle
  wire       req = avs_read_i | avs_write_i;
  wire       wr  = avs_write_i & ack;
  wire [2:0] grp = avs_address_i[7:5];
  wire [2:0] asl = avs_address_i[4:2];
  wire       slot_ok = (asl != 3'h7) && (avs_address_i[1:0] == 2'h0);
  assign avs_waitrequest_o = req & ~ack;

  wire        sel_ok  = (msel == `MSEL_VIRTUAL) || !msel[3];
  wire [31:0] sel_pos = (msel == `MSEL_VIRTUAL) ? virtual_pos_i
                        : axis_pos_i[{msel[2:0], 5'h00} +: 32];

  wire               step  = en && sample_tick_i && (st == S_IDLE) && sel_ok;
  wire [31:0]        delta = sel_pos - prev_pos;
  wire signed [32:0] sum   = $signed({10'h000, phase}) + $signed({delta[31], delta});
  wire               wrap_f = sum >= $signed({10'h000, mcyc});
  wire               wrap_r = sum < $signed(33'h000000000);
  wire [32:0]        wrapped = wrap_f ? sum - {10'h000, mcyc}
                               : wrap_r ? sum + {10'h000, mcyc} : sum;
  // phase relative to the first table point
  wire [22:0] rel = (phase >= orig) ? phase - orig : phase - orig + mcyc;

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h00000000;
      msel           <= `MSEL_RST;
      en             <= 1'b0;
      mcyc           <= `MCYC_RST;
      intv           <= `INTV_RST;
      orig           <= `ORIG_RST;
      taddr          <= 12'h000;
      ycnt           <= 32'h00000000;
      phase          <= 23'h000000;
      old_phase      <= 23'h000000;
      prev_pos       <= 32'h00000000;
      evt            <= 1'b0;
      ev_fwd         <= 1'b0;
      ev_wrap        <= 1'b0;
    end else begin
      ack <= req & ~ack;
      evt <= 1'b0;
      if (req & ~ack)
        avs_readdata_o <= rd_mux;
      if (!en)
        prev_pos <= sel_pos;
      else if (step) begin
        prev_pos  <= sel_pos;
        old_phase <= phase;
        phase     <= wrapped[22:0];
        evt       <= 1'b1;
        ev_fwd    <= !delta[31];
        ev_wrap   <= wrap_f | wrap_r;
        // count the wrap, phase folds back by one master cycle
        if (wrap_f)
          ycnt <= ycnt + 32'h00000001;
        else if (wrap_r)
          ycnt <= ycnt - 32'h00000001;
      end
      if (wr) begin
        case (avs_address_i)
          `R_MSEL:      msel  <= avs_writedata_i[3:0];
          // on with 1, off with 0
          `R_ENABLE:    en    <= avs_writedata_i[0];
          // master cycle held in 23 bits
          `R_MCYCLE:    mcyc  <= avs_writedata_i[22:0];
          `R_INTERVAL:  intv  <= avs_writedata_i[22:0];
          `R_ORIGIN:    orig  <= avs_writedata_i[22:0];
          `R_TBL_ADDR:  taddr <= avs_writedata_i[11:0];
          `R_CYCLE_CNT: ycnt  <= avs_writedata_i;
          default:      ;
        endcase
      end
    end
  end

  // per-slave configuration words
  always @(posedge mclk_i or negedge rst_n_i) begin : cfg
    integer k;
    if (!rst_n_i) begin
      for (k = 0; k < `CAM_NSLV; k = k + 1) begin
        chg[k]  <= 31'h00000000;
        engp[k] <= 32'h00000000;
        disp[k] <= 32'h00000000;
      end
    end else if (wr && slot_ok) begin
      if (grp == `G_CHANGE)
        chg[asl] <= avs_writedata_i[30:0];
      if (grp == `G_ENGAGE)
        engp[asl] <= avs_writedata_i;
      if (grp == `G_DISENGAGE)
        disp[asl] <= avs_writedata_i;
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    case (avs_address_i)
      `R_MSEL:      rd_mux = {28'h0000000, msel};
      `R_ENABLE:    rd_mux = {31'h00000000, en};
      `R_MCYCLE:    rd_mux = {9'h000, mcyc};
      `R_INTERVAL:  rd_mux = {9'h000, intv};
      `R_ORIGIN:    rd_mux = {9'h000, orig};
      `R_TBL_ADDR:  rd_mux = {20'h00000, taddr};
      `R_INDEX:     rd_mux = {23'h000000, idx};
      `R_CYCLE_CNT: rd_mux = ycnt;
      `R_STATUS:    rd_mux = {9'h000, arm_d, 1'b0, arm_e, 1'b0, engaged};
      `R_PHASE:     rd_mux = {9'h000, phase};
      default: begin
        if (slot_ok && grp == `G_CHANGE)
          rd_mux = {1'b0, chg[asl]};
        else if (slot_ok && grp == `G_ENGAGE)
          rd_mux = engp[asl];
        else if (slot_ok && grp == `G_DISENGAGE)
          rd_mux = disp[asl];
        else if (slot_ok && grp == `G_SLAVE_POS)
          rd_mux = spos[asl];
      end
    endcase
  end

  // true when the master passed pt during the last step
  function crossed;
    input [22:0] from;
    input [22:0] to;
    input [31:0] pt;
    input        fwd;
    input        wrap;
    reg          up;
    reg          dn;
    begin
      up = {9'h000, from} < pt;
      dn = pt <= {9'h000, to};
      if (fwd)
        crossed = wrap ? (up || dn) : (up && dn);
      else
        crossed = wrap ? ({9'h000, from} > pt || pt >= {9'h000, to})
                       : ({9'h000, from} > pt && pt >= {9'h000, to});
    end
  endfunction

  genvar s;
  generate
    for (s = 0; s < `CAM_NSLV; s = s + 1) begin : slave
      reg  eng_q;
      reg  arm_e_q;
      reg  arm_d_q;
      wire hit  = wr && slot_ok && (asl == s);
      wire we_e = hit && (grp == `G_ENGAGE);
      wire we_d = hit && (grp == `G_DISENGAGE);
      wire out_of_cycle = avs_writedata_i >= {9'h000, mcyc};
      always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          eng_q   <= 1'b0;
          arm_e_q <= 1'b0;
          arm_d_q <= 1'b0;
        end else if (!en) begin
          eng_q   <= 1'b0;
          arm_e_q <= 1'b0;
          arm_d_q <= 1'b0;
        end else begin
          // outside the cycle engages at once
          if (we_e) begin
            arm_e_q <= !out_of_cycle;
            if (out_of_cycle)
              eng_q <= 1'b1;
          end else if (evt && arm_e_q &&
                       crossed(old_phase, phase, engp[s], ev_fwd, ev_wrap)) begin
            eng_q   <= 1'b1;
            arm_e_q <= 1'b0;
          end
          // outside the cycle stops at once
          if (we_d) begin
            arm_d_q <= !out_of_cycle;
            if (out_of_cycle)
              eng_q <= 1'b0;
          end else if (evt && arm_d_q &&
                       crossed(old_phase, phase, disp[s], ev_fwd, ev_wrap)) begin
            eng_q   <= 1'b0;
            arm_d_q <= 1'b0;
          end
        end
      end
      assign engaged[s] = eng_q;
      assign arm_e[s]   = arm_e_q;
      assign arm_d[s]   = arm_d_q;
      assign slave_pos_o[s*32 +: 32] = spos[s];
    end
  endgenerate

  assign slave_engaged_o = engaged;
  assign cam_active_o    = en;

  wire signed [32:0] diff = $signed({rdata[31], rdata}) - $signed({pa[31], pa});
  wire [32:0]        mag  = diff[32] ? 33'h000000000 - diff : diff;
  wire [55:0]        prod = mag * frac;
  wire [31:0]        step_q = neg ? 32'h00000000 - dv_q[31:0] : dv_q[31:0];
  wire signed [31:0] val  = $signed(pa) + $signed(step_q);
  wire signed [32:0] cv   = $signed({1'b0, 1'b0, chg[slv]});
  wire signed [32:0] val_x = {val[31], val};
  wire signed [32:0] folded = (cv == 33'h000000000) ? val_x
                              : (val_x >= cv) ? val_x - cv
                              : (val_x < $signed(33'h000000000)) ? val_x + cv : val_x;

  always @(posedge mclk_i or negedge rst_n_i) begin : seq
    integer k;
    if (!rst_n_i) begin
      st          <= S_IDLE;
      slv         <= 3'h0;
      idx         <= 9'h000;
      frac        <= 23'h000000;
      pa          <= 32'h00000000;
      neg         <= 1'b0;
      raddr       <= 12'h000;
      dv_start    <= 1'b0;
      dv_dividend <= {`CAM_DIV_W{1'b0}};
      for (k = 0; k < `CAM_NSLV; k = k + 1)
        spos[k] <= 32'h00000000;
    end else begin
      dv_start <= 1'b0;
      if (wr && avs_address_i == `R_INDEX)
        idx <= avs_writedata_i[8:0];
      case (st)
        S_IDLE: begin
          if (evt && intv != 23'h000000) begin
            dv_dividend <= {33'h000000000, rel};
            dv_start    <= 1'b1;
            st          <= S_DIVI;
          end
        end
        S_DIVI: begin
          if (dv_done) begin
            idx   <= (dv_q > {47'h000000000000, `CAM_MAX_IDX}) ? `CAM_MAX_IDX : dv_q[8:0];
            frac  <= dv_r;
            raddr <= {((dv_q > {47'h000000000000, `CAM_MAX_IDX}) ? `CAM_MAX_IDX
                       : dv_q[8:0]), 3'h0};
            slv   <= 3'h0;
            st    <= S_RDA;
          end
        end
        S_RDA: begin
          raddr <= {idx + 9'h001, slv};
          st    <= S_RDB;
        end
        S_RDB: begin
          pa <= rdata;
          st <= S_RDC;
        end
        S_RDC: begin
          neg         <= diff[32];
          dv_dividend <= prod;
          dv_start    <= 1'b1;
          st          <= S_DIVS;
        end
        S_DIVS: begin
          if (dv_done) begin
            // slave spans zero to its change
            if (engaged[slv])
              spos[slv] <= folded[31:0];
            if (slv == `CAM_SLV_LAST)
              st <= S_IDLE;
            else begin
              slv   <= slv + 3'h1;
              raddr <= {idx, slv + 3'h1};
              st    <= S_RDA;
            end
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  cam_table u_table (
    .mclk_i  (mclk_i),
    .we_i    (wr && avs_address_i == `R_TBL_DATA),
    .waddr_i (taddr),
    .wdata_i (avs_writedata_i),
    .raddr_i (raddr),
    .rdata_o (rdata)
  );

  cam_divider u_div (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .start_i     (dv_start),
    .dividend_i  (dv_dividend),
    .divisor_i   (intv),
    .quotient_o  (dv_q),
    .remainder_o (dv_r),
    .done_o      (dv_done)
  );
endmodule

// *** sim/cam_follower_monitor.sv ***
// bus and engagement checks for the cam follower, bound to its ports
// assumes the single clock mclk_i and the async low reset rst_n_i
`timescale 1ns/1ps
`include "cam_map.vh"
module cam_follower_monitor (
  input wire         mclk_i,
  input wire         rst_n_i,
  input wire [7:0]   avs_address_i,
  input wire         avs_read_i,
  input wire         avs_write_i,
  input wire [31:0]  avs_writedata_i,
  input wire [31:0]  avs_readdata_o,
  input wire         avs_waitrequest_o,
  input wire         sample_tick_i,
  input wire [255:0] axis_pos_i,
  input wire [31:0]  virtual_pos_i,
  input wire [223:0] slave_pos_o,
  input wire [6:0]   slave_engaged_o,
  input wire         cam_active_o
);
  wire rq = avs_read_i | avs_write_i;
  wire ack = rq & ~avs_waitrequest_o;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_idle_no_wait: assert property (!rq |-> !avs_waitrequest_o)
    else $error("waitrequest high while idle");
  a_first_cycle_wait: assert property ((rq && !$past(rq)) |-> avs_waitrequest_o)
    else $error("request answered without its wait cycle");
  a_single_wait: assert property ((rq && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("more than one wait cycle");
  a_enable_write: assert property ((avs_write_i && ack && avs_address_i == `R_ENABLE)
    |=> cam_active_o == $past(avs_writedata_i[0]))
    else $error("enable write not reflected");
  a_enable_read: assert property ((avs_read_i && ack && avs_address_i == `R_ENABLE)
    |-> avs_readdata_o == {31'h0, cam_active_o})
    else $error("enable readback wrong");
  a_hole_reads_zero: assert property ((avs_read_i && ack && (avs_address_i == `R_TBL_DATA
    || avs_address_i == 8'h5c || avs_address_i == 8'h2c)) |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_engage_needs_on: assert property (((slave_engaged_o & ~$past(slave_engaged_o)) != 7'h0)
    |-> cam_active_o)
    else $error("slave engaged while cam off");
  a_off_clears: assert property (!cam_active_o |=> slave_engaged_o == 7'h0)
    else $error("engaged slave while cam off");
  // out-of-cycle engage or disengage points act on the write itself
  a_engage_on_tick: assert property ((slave_engaged_o != $past(slave_engaged_o)) |->
    ($past(sample_tick_i, 2) || $past(sample_tick_i, 3) || !cam_active_o
     || $past(avs_write_i && !avs_waitrequest_o && (avs_address_i[7:5] == `G_ENGAGE
        || avs_address_i[7:5] == `G_DISENGAGE))))
    else $error("engagement changed without a tick");
endmodule

bind cam_follower cam_follower_monitor u_cam_follower_monitor (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .sample_tick_i(sample_tick_i), .axis_pos_i(axis_pos_i), .virtual_pos_i(virtual_pos_i),
  .slave_pos_o(slave_pos_o), .slave_engaged_o(slave_engaged_o),
  .cam_active_o(cam_active_o)
);

// *** sim/master_encoder.sv ***
// encoder counters of the eight axes and the virtual axis, plus the servo tick
// assumes go_i is a one-cycle request from the bench on mclk_i
`timescale 1ns/1ps
module master_encoder (
  input  wire         mclk_i,
  input  wire         rst_n_i,
  input  wire         go_i,
  input  wire [31:0]  step_i,
  output reg  [255:0] axis_pos_o,
  output reg  [31:0]  virtual_pos_o,
  output reg          sample_tick_o
);
  integer n;
  // main encoder counts
  // axis n moves (n+1) steps so each master choice shows a distinct rate
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      axis_pos_o <= 256'h0;
      virtual_pos_o <= 32'h0;
      sample_tick_o <= 1'b0;
    end else begin
      sample_tick_o <= go_i;
      if (go_i) begin
        for (n = 0; n < 8; n = n + 1)
          axis_pos_o[32*n +: 32] <= axis_pos_o[32*n +: 32] + step_i * (n + 1);
        virtual_pos_o <= virtual_pos_o + step_i * 9;
      end
    end
  end
endmodule

// *** sim/tb_top.sv ***
// self-checking bench: registers, master choice, cam profile and engagement
// assumes the cam follower design and the master_encoder partner model
`timescale 1ns/1ps
`include "cam_map.vh"
module tb_top;
  logic         mclk_i          = 1'b0;
  logic         rst_n_i         = 1'b0;
  logic [7:0]   avs_address_i   = 8'h00;
  logic         avs_read_i      = 1'b0;
  logic         avs_write_i     = 1'b0;
  logic [31:0]  avs_writedata_i = 32'h0;
  logic         go              = 1'b0;
  logic [31:0]  step            = 32'h0;
  logic [31:0]  q;
  logic [31:0]  p0;
  wire  [31:0]  avs_readdata_o;
  wire          avs_waitrequest_o;
  wire          sample_tick;
  wire  [255:0] axis_pos;
  wire  [31:0]  virtual_pos;
  wire  [223:0] slave_pos_o;
  wire  [6:0]   slave_engaged_o;
  wire          cam_active_o;
  integer       failures = 0;
  integer       n_tests  = 0;
  integer       k;
  logic [7:0]   ra [0:10] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h40, 8'h58, 8'h1c, 8'h20,
                              8'h5c, 8'h2c, 8'h18};
  logic [31:0]  rw [0:10] = '{32'h5, 32'hffffffff, 32'h7d0, 32'hffffffff, 32'hffffffff,
                              32'h1234, 32'h105, 32'h7, 32'h1, 32'h1, 32'h1};
  logic [31:0]  re [0:10] = '{32'h5, 32'h7fffff, 32'h7d0, 32'h7fffff, 32'h7fffffff,
                              32'h1234, 32'h105, 32'h7, 32'h0, 32'h0, 32'h0};

  always #20 mclk_i = ~mclk_i;

  cam_follower u_cam_follower (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .sample_tick_i(sample_tick), .axis_pos_i(axis_pos), .virtual_pos_i(virtual_pos),
    .slave_pos_o(slave_pos_o), .slave_engaged_o(slave_engaged_o),
    .cam_active_o(cam_active_o));

  master_encoder u_master_encoder (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .go_i(go), .step_i(step),
    .axis_pos_o(axis_pos), .virtual_pos_o(virtual_pos), .sample_tick_o(sample_tick));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      failures = failures + 1;
    end
  endtask

  // one idle edge first so a release and the next request never share a time step
  // waits for the answer as long as it takes; only the watchdog ends a hang
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    @(posedge mclk_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge mclk_i);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task tick;
    @(posedge mclk_i);
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    // computation takes about 500 cycles
    repeat (700) @(posedge mclk_i);
  endtask

  // table 0, 2000, 1000, 0 at master 0, 2000, 4000, 6000
  function logic [31:0] exp_pos(input integer p);
    integer i, off, b, e;
    i = p / 2000;
    off = p % 2000;
    b = (i == 1) ? 2000 : (i == 2) ? 1000 : 0;
    e = (i == 0) ? 2000 : (i == 1) ? 1000 : 0;
    exp_pos = 32'(b + (e - b) * off / 2000);
  endfunction

  task t_regs;
    for (k = 0; k < 5; k = k + 1) begin
      bus(1'b0, 8'(4 * k), 32'h0);
      chk(q, 32'h0);
    end
    for (k = 0; k < 11; k = k + 1) begin
      bus(1'b1, ra[k], rw[k]);
      bus(1'b0, ra[k], 32'h0);
      chk(q, re[k]);
    end
    $display("test regs done");
  endtask

  task t_select;
    bus(1'b1, `R_MCYCLE, 32'd1000);
    bus(1'b1, `R_ENABLE, 32'h1);
    @(negedge mclk_i);
    chk({31'h0, cam_active_o}, 32'h1);
    step = 32'd5;
    for (k = 0; k < 9; k = k + 1) begin
      bus(1'b1, `R_MSEL, 32'(k));
      tick;
      bus(1'b0, `R_PHASE, 32'h0);
      p0 = q;
      tick;
      bus(1'b0, `R_PHASE, 32'h0);
      chk((q + 32'd1000 - p0) % 32'd1000, 32'(5 * (k + 1)));
      chk({31'h0, q < 32'd1000}, 32'h1);
    end
    $display("test select done");
  endtask

  task t_cam;
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    bus(1'b1, `R_MCYCLE, 32'd6000);
    bus(1'b1, `R_INTERVAL, 32'd2000);
    bus(1'b1, `R_ORIGIN, 32'd0);
    bus(1'b1, 8'h44, 32'd4000);
    for (k = 0; k < 4; k = k + 1) begin
      bus(1'b1, `R_TBL_ADDR, 32'(k * 8 + 1));
      bus(1'b1, `R_TBL_DATA, exp_pos(k * 2000));
    end
    // engagement is only kept while cam mode is on
    bus(1'b1, `R_ENABLE, 32'h1);
    bus(1'b1, 8'h64, 32'hffffffff);
    step = 32'd500;
    for (k = 1; k <= 18; k = k + 1) begin
      tick;
      bus(1'b0, `R_PHASE, 32'h0);
      chk(q, 32'((500 * k) % 6000));
      if (k >= 2) chk({25'h0, slave_engaged_o}, 32'h2);
      if (k >= 2) chk(slave_pos_o[63:32], exp_pos((500 * k) % 6000));
    end
    bus(1'b0, `R_CYCLE_CNT, 32'h0);
    chk(q, 32'h1);
    bus(1'b0, `R_INDEX, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, 8'h84, 32'd3200);
    tick;
    chk({25'h0, slave_engaged_o}, 32'h0);
    chk(slave_pos_o[63:32], 32'd1500);
    bus(1'b1, 8'h64, 32'd1000);
    bus(1'b0, `R_STATUS, 32'h0);
    chk(q, 32'h200);
    for (k = 20; k <= 26; k = k + 1) begin
      tick;
      chk({31'h0, slave_engaged_o[1]}, {31'h0, k == 26});
    end
    chk(slave_pos_o[63:32], 32'd1000);
    bus(1'b1, 8'h84, 32'hffffffff);
    tick;
    chk({25'h0, slave_engaged_o}, 32'h0);
    bus(1'b1, `R_ENABLE, 32'h0);
    @(negedge mclk_i);
    chk({31'h0, cam_active_o}, 32'h0);
    bus(1'b0, `R_PHASE, 32'h0);
    p0 = q;
    tick;
    bus(1'b0, `R_PHASE, 32'h0);
    chk(q, p0);
    $display("test cam done");
  endtask

  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_select;
    t_cam;
    finish_test;
  end

  // run needs roughly 35000 cycles
  initial begin
    repeat (90000) @(posedge mclk_i);
    failures = failures + 1;
    finish_test;
  end
endmodule
